// ### hdl/dcc_map.svh
// Register map, field positions, codes and reset values of the dual comparator control block.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DCC_IDX_COMP0_CTRL 6'h00
`define DCC_IDX_COMP1_CTRL 6'h01
`define DCC_IDX_COMP0_INSEL 6'h02
`define DCC_IDX_COMP1_INSEL 6'h03
`define DCC_IDX_PIN_ROUTE 6'h04
`define DCC_IDX_SCALER 6'h05
`define DCC_IDX_WINDOW 6'h06
`define DCC_IDX_STATUS 6'h07
`define DCC_IDX_CURR_CTRL 6'h08
`define DCC_IDX_CURR_TRIM 6'h09

// ----------------------------------------------------------------
// Writable bit masks; reserved bits store and read as zero
// ----------------------------------------------------------------
`define DCC_MASK_CTRL 8'hf7
`define DCC_MASK_INSEL 8'h3f
`define DCC_MASK_ROUTE 8'h03
`define DCC_MASK_SCALER 8'h3f
`define DCC_MASK_WINDOW 8'h1f
`define DCC_MASK_CURR 8'h83
`define DCC_MASK_TRIM 8'h0f
`define DCC_RESET_VAL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCC_CTRL_ENABLE 0
`define DCC_CTRL_HYST_LSB 1
`define DCC_CTRL_LVL_LSB 4
`define DCC_CTRL_EDGE_LSB 6
`define DCC_INSEL_NEG_LSB 0
`define DCC_INSEL_POS_LSB 3
`define DCC_ROUTE_COMP0 0
`define DCC_ROUTE_COMP1 1
`define DCC_WIN_LVL_LSB 0
`define DCC_WIN_COND_LSB 2
`define DCC_WIN_ENABLE 4
`define DCC_CURR_COMP0 0
`define DCC_CURR_COMP1 1
`define DCC_CURR_ENABLE 7

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define DCC_EDGE_TOGGLE 2'b00
`define DCC_EDGE_FALL 2'b10
`define DCC_EDGE_RISE 2'b11
`define DCC_WIN_ABOVE 2'b00
`define DCC_WIN_INSIDE 2'b01
`define DCC_WIN_BELOW 2'b10
`define DCC_WIN_OUTSIDE 2'b11
`define DCC_NEG_PIN0 3'b000
`define DCC_NEG_PIN1 3'b001
`define DCC_NEG_PIN3 3'b010
`define DCC_NEG_PIN5 3'b011
`define DCC_NEG_PIN7 3'b100

`endif

// ### hdl/dcc_pkg.sv
// Types shared by the dual comparator control block.
// Assumes no include path; it does not include or use the map header.
package dcc_pkg;

  // ----------------------------------------------------------------
  // Per-comparator configuration carried to the analog side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic [1:0] hysteresis;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
  } dcc_comp_cfg_t;

  // Interrupt request with priority level, zero means no request
  typedef struct packed {
    logic [1:0] window_irq_level;
    logic [1:0] comp1_irq_level;
    logic [1:0] comp0_irq_level;
  } dcc_irq_t;

  // Register slave phase
  typedef enum logic [0:0] {
    DCC_PH_IDLE,
    DCC_PH_ANSWER
  } dcc_apb_phase_t;

endpackage : dcc_pkg

// ### hdl/dcc_comp_chan.sv
// One comparator channel: result synchroniser, enable gating and edge event.
// Assumes the raw result comes from the analog comparator, asynchronous to pclk.
`include "dcc_map.svh"

module dcc_comp_chan (
  input wire logic pclk, // Peripheral clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic raw_result, // Analog comparator result, asynchronous
  input wire logic enable, // Comparator enable
  input wire logic [1:0] edge_sel, // Edge trigger select
  output logic live_q, // Filtered, enabled result
  output logic event_q // One-cycle edge event
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic live_d;
  logic hit;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Three stages; only the second and third are compared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= raw_result;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // enable gates result
  // A disabled comparator reads as zero so stale results never raise events
  always_comb begin
    live_d = live_q;
    if (!enable) begin
      live_d = 1'b0;
    end else if (sync2_q == sync3_q) begin
      live_d = sync3_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q <= 1'b0;
    end else begin
      live_q <= live_d;
    end
  end

  // ----------------------------------------------------------------
  // Edge event
  // ----------------------------------------------------------------
  // edge mode decode
  always_comb begin
    hit = 1'b0;
    unique case (edge_sel)
      `DCC_EDGE_TOGGLE: hit = live_d != live_q;
      `DCC_EDGE_FALL: hit = !live_d && live_q;
      `DCC_EDGE_RISE: hit = live_d && !live_q;
      default: hit = 1'b0; // Reserved code raises nothing
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= 1'b0;
    end else begin
      event_q <= enable && hit;
    end
  end

endmodule : dcc_comp_chan

// ### hdl/dcc_top.sv
// Dual comparator control: APB register file, window logic, flags and current source.
// Assumes an APB master on pclk and two analog comparators driving raw results.
`include "dcc_map.svh"

module dcc_top (
  input wire logic pclk, // Peripheral clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic comp0_raw, // Comparator zero analog result
  input wire logic comp1_raw, // Comparator one analog result
  input wire logic [2:0] vector_ack, // Vector executed: window, one, zero
  output dcc_pkg::dcc_comp_cfg_t comp0_cfg, // Comparator zero settings
  output dcc_pkg::dcc_comp_cfg_t comp1_cfg, // Comparator one settings
  output logic [5:0] scaler_factor, // Supply scaler factor
  output logic pin6_out, // Pin 6 drive value
  output logic pin6_oe, // Pin 6 drive enable
  output logic pin7_out, // Pin 7 drive value
  output logic pin7_oe, // Pin 7 drive enable
  output logic current_enable, // Constant current source on
  output logic [7:0] current_pin_en, // Current output per port pin
  output logic [3:0] current_trim_value, // Current source trim
  output logic [2:0] event_out, // Events: window, one, zero
  output dcc_pkg::dcc_irq_t irq_req // Interrupt requests with levels
);

  logic [7:0] ctrl_q [2];
  logic [7:0] insel_q [2];
  logic [7:0] route_q;
  logic [7:0] scaler_q;
  logic [7:0] window_q;
  logic [7:0] curr_q;
  logic [7:0] trim_q;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [1:0] live;
  logic [1:0] edge_evt;
  logic [1:0] window_position;
  logic win_hit;
  logic win_hit_q;
  logic win_evt_q;
  logic [31:0] rd_data;
  logic addr_hit;
  logic wr_fire;
  logic [2:0] flag_wclr;
  dcc_pkg::dcc_apb_phase_t phase_q;
  logic [5:0] idx;

  // ----------------------------------------------------------------
  // Comparator channels
  // ----------------------------------------------------------------
  // One instance per comparator; edge decode is identical for both
  dcc_comp_chan u_chan0 (
    .pclk(pclk),
    .presetn(presetn),
    .raw_result(comp0_raw),
    .enable(ctrl_q[0][`DCC_CTRL_ENABLE]),
    .edge_sel(ctrl_q[0][`DCC_CTRL_EDGE_LSB +: 2]),
    .live_q(live[0]),
    .event_q(edge_evt[0])
  );

  dcc_comp_chan u_chan1 (
    .pclk(pclk),
    .presetn(presetn),
    .raw_result(comp1_raw),
    .enable(ctrl_q[1][`DCC_CTRL_ENABLE]),
    .edge_sel(ctrl_q[1][`DCC_CTRL_EDGE_LSB +: 2]),
    .live_q(live[1]),
    .event_q(edge_evt[1])
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Misaligned or unknown addresses answer with an error and no effect
  assign idx = paddr[7:2];
  assign addr_hit = (paddr[1:0] == 2'b00) && (idx <= `DCC_IDX_CURR_TRIM);
  assign wr_fire = psel && penable && pready && pwrite && addr_hit && pstrb[0];

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (idx)
      `DCC_IDX_COMP0_CTRL: rd_data[7:0] = ctrl_q[0];
      `DCC_IDX_COMP1_CTRL: rd_data[7:0] = ctrl_q[1];
      `DCC_IDX_COMP0_INSEL: rd_data[7:0] = insel_q[0];
      `DCC_IDX_COMP1_INSEL: rd_data[7:0] = insel_q[1];
      `DCC_IDX_PIN_ROUTE: rd_data[7:0] = route_q;
      `DCC_IDX_SCALER: rd_data[7:0] = scaler_q;
      `DCC_IDX_WINDOW: rd_data[7:0] = window_q;
      `DCC_IDX_STATUS: rd_data[7:0] = {window_position, live[1], live[0], 1'b0, flags_q};
      `DCC_IDX_CURR_CTRL: rd_data[7:0] = curr_q;
      `DCC_IDX_CURR_TRIM: rd_data[7:0] = trim_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Answer one cycle after setup so that every bus output leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= dcc_pkg::DCC_PH_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      unique case (phase_q)
        dcc_pkg::DCC_PH_IDLE: begin
          if (psel && !penable) begin
            phase_q <= dcc_pkg::DCC_PH_ANSWER;
            pready <= 1'b1;
            pslverr <= !addr_hit;
            prdata <= (!pwrite && addr_hit) ? rd_data : 32'h0000_0000;
          end
        end
        dcc_pkg::DCC_PH_ANSWER: begin
          phase_q <= dcc_pkg::DCC_PH_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // reserved bits store zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q[0] <= `DCC_RESET_VAL;
      ctrl_q[1] <= `DCC_RESET_VAL;
      insel_q[0] <= `DCC_RESET_VAL;
      insel_q[1] <= `DCC_RESET_VAL;
      route_q <= `DCC_RESET_VAL;
      scaler_q <= `DCC_RESET_VAL;
      window_q <= `DCC_RESET_VAL;
      curr_q <= `DCC_RESET_VAL;
      trim_q <= `DCC_RESET_VAL;
    end else if (wr_fire) begin
      unique case (idx)
        `DCC_IDX_COMP0_CTRL: ctrl_q[0] <= pwdata[7:0] & `DCC_MASK_CTRL;
        `DCC_IDX_COMP1_CTRL: ctrl_q[1] <= pwdata[7:0] & `DCC_MASK_CTRL;
        `DCC_IDX_COMP0_INSEL: insel_q[0] <= pwdata[7:0] & `DCC_MASK_INSEL;
        `DCC_IDX_COMP1_INSEL: insel_q[1] <= pwdata[7:0] & `DCC_MASK_INSEL;
        `DCC_IDX_PIN_ROUTE: route_q <= pwdata[7:0] & `DCC_MASK_ROUTE;
        `DCC_IDX_SCALER: scaler_q <= pwdata[7:0] & `DCC_MASK_SCALER;
        `DCC_IDX_WINDOW: window_q <= pwdata[7:0] & `DCC_MASK_WINDOW;
        `DCC_IDX_CURR_CTRL: curr_q <= pwdata[7:0] & `DCC_MASK_CURR;
        `DCC_IDX_CURR_TRIM: trim_q <= pwdata[7:0] & `DCC_MASK_TRIM;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Window logic
  // ----------------------------------------------------------------
  // position from both results
  // Comparator zero guards the upper bound, comparator one the lower;
  // zero high with one low cannot occur with ordered bounds and reads outside
  // position reported in window mode
  always_comb begin
    window_position = `DCC_WIN_ABOVE;
    if (window_q[`DCC_WIN_ENABLE]) begin
      unique case ({live[0], live[1]})
        2'b11: window_position = `DCC_WIN_ABOVE;
        2'b01: window_position = `DCC_WIN_INSIDE;
        2'b00: window_position = `DCC_WIN_BELOW;
        2'b10: window_position = `DCC_WIN_OUTSIDE;
      endcase
    end
  end

  always_comb begin
    win_hit = 1'b0;
    unique case (window_q[`DCC_WIN_COND_LSB +: 2])
      `DCC_WIN_ABOVE: win_hit = window_position == `DCC_WIN_ABOVE;
      `DCC_WIN_INSIDE: win_hit = window_position == `DCC_WIN_INSIDE;
      `DCC_WIN_BELOW: win_hit = window_position == `DCC_WIN_BELOW;
      `DCC_WIN_OUTSIDE: win_hit = window_position != `DCC_WIN_INSIDE;
    endcase
    win_hit = win_hit && window_q[`DCC_WIN_ENABLE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_hit_q <= 1'b0;
      win_evt_q <= 1'b0;
    end else begin
      win_hit_q <= win_hit;
      win_evt_q <= win_hit && !win_hit_q;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign flag_wclr = (wr_fire && idx == `DCC_IDX_STATUS) ? pwdata[2:0] : 3'b000;

  // window, comparator one and comparator zero flags
  // A set in the same cycle as a clear wins so no event is lost
  always_comb begin
    flags_d = (flags_q & ~(flag_wclr | vector_ack)) | {win_evt_q, edge_evt};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 3'b000;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Configuration fields straight from their registers
  assign comp0_cfg = {ctrl_q[0][`DCC_CTRL_ENABLE], ctrl_q[0][`DCC_CTRL_HYST_LSB +: 2], insel_q[0][5:0]};
  assign comp1_cfg = {ctrl_q[1][`DCC_CTRL_ENABLE], ctrl_q[1][`DCC_CTRL_HYST_LSB +: 2], insel_q[1][5:0]};
  assign scaler_factor = scaler_q[5:0];
  assign current_trim_value = trim_q[3:0];
  assign current_enable = curr_q[`DCC_CURR_ENABLE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin6_out <= 1'b0;
      pin6_oe <= 1'b0;
      pin7_out <= 1'b0;
      pin7_oe <= 1'b0;
    end else begin
      pin6_out <= live[1];
      pin6_oe <= route_q[`DCC_ROUTE_COMP1];
      pin7_out <= live[0];
      pin7_oe <= route_q[`DCC_ROUTE_COMP0];
    end
  end

  // Negative select code to one-hot pin; internal references carry no pin
  function automatic logic [7:0] dcc_neg_pin(input logic [2:0] sel);
    logic [7:0] pins;
    pins = 8'h00;
    unique case (sel)
      `DCC_NEG_PIN0: pins = 8'h01;
      `DCC_NEG_PIN1: pins = 8'h02;
      `DCC_NEG_PIN3: pins = 8'h08;
      `DCC_NEG_PIN5: pins = 8'h20;
      `DCC_NEG_PIN7: pins = 8'h80;
      default: pins = 8'h00;
    endcase
    return pins;
  endfunction : dcc_neg_pin

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_pin_en <= 8'h00;
    end else if (!curr_q[`DCC_CURR_ENABLE]) begin
      current_pin_en <= 8'h00;
    end else begin
      current_pin_en <= (curr_q[`DCC_CURR_COMP0] ? dcc_neg_pin(insel_q[0][2:0]) : 8'h00)
                      | (curr_q[`DCC_CURR_COMP1] ? dcc_neg_pin(insel_q[1][2:0]) : 8'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= '0;
      event_out <= 3'b000;
    end else begin
      irq_req.window_irq_level <= flags_d[2] ? window_q[`DCC_WIN_LVL_LSB +: 2] : 2'b00;
      irq_req.comp1_irq_level <= flags_d[1] ? ctrl_q[1][`DCC_CTRL_LVL_LSB +: 2] : 2'b00;
      irq_req.comp0_irq_level <= flags_d[0] ? ctrl_q[0][`DCC_CTRL_LVL_LSB +: 2] : 2'b00;
      event_out <= {win_evt_q, edge_evt};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_clear_only;
    flag_wclr[0] && !edge_evt[0];
  endsequence

  a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");
  a_flag_set_wins: assert property (edge_evt[1] |=> flags_q[1])
    else $error("Comparator one event lost");
  a_flag_write_clear: assert property (s_clear_only |=> !flags_q[0])
    else $error("Comparator zero flag not cleared by write");
  a_window_ack: assert property (vector_ack[2] && !win_evt_q |=> !flags_q[2])
    else $error("Window flag not cleared by vector");
  a_window_off: assert property (!window_q[`DCC_WIN_ENABLE] |-> window_position == 2'b00 && !win_hit)
    else $error("Window logic active while disabled");
  a_pin7_route: assert property (route_q[`DCC_ROUTE_COMP0] |=> pin7_oe && pin7_out == $past(live[0]))
    else $error("Pin 7 does not follow comparator zero");
  a_current_off: assert property (!curr_q[`DCC_CURR_ENABLE] |=> current_pin_en == 8'h00)
    else $error("Current routed while source off");
  a_irq_level: assert property (flags_q[0] && ctrl_q[0][5:4] == 2'b00 |-> irq_req.comp0_irq_level == 2'b00
                                 || $past(ctrl_q[0][5:4]) != 2'b00)
    else $error("Interrupt requested at level zero");
  a_disabled_quiet: assert property (!ctrl_q[1][`DCC_CTRL_ENABLE] |=> !live[1] && !edge_evt[1])
    else $error("Disabled comparator produced output");

endmodule : dcc_top

// ### tb/dcc_analog_model.sv
// Behavioural comparators and port pins facing the control block.
// Assumes pin levels come from the bench in steps of a 64-step supply.
module dcc_analog_model #(
  parameter int VCC = 64, // Supply level
  parameter int BANDGAP = 20 // Bandgap level, arbitrary
) (
  input wire logic [7:0][6:0] pin_lvl, // Port pin levels
  input wire dcc_pkg::dcc_comp_cfg_t cfg0, // Comparator zero settings
  input wire dcc_pkg::dcc_comp_cfg_t cfg1, // Comparator one settings
  input wire logic [5:0] fac, // Scaler factor
  output logic raw0, // Comparator zero result
  output logic raw1 // Comparator one result
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic int pos_lvl(input logic [2:0] s);
    return (s == 3'b111) ? 0 : int'(pin_lvl[s]);
  endfunction : pos_lvl
  function automatic int neg_lvl(input logic [2:0] s);
    case (s)
      3'b000: return int'(pin_lvl[0]);
      3'b001: return int'(pin_lvl[1]);
      3'b010: return int'(pin_lvl[3]);
      3'b011: return int'(pin_lvl[5]);
      3'b100: return int'(pin_lvl[7]);
      3'b110: return BANDGAP;
      3'b111: return VCC * (int'(fac) + 1) / 64;
      default: return VCC;
    endcase
  endfunction : neg_lvl
  // result only while switched on; off reads low
  // Procedural on purpose: a change of pin level or scaler must re-run the functions
  always_comb begin
    raw0 = cfg0.enable && (pos_lvl(cfg0.positive_input_select) > neg_lvl(cfg0.negative_input_select));
  end
  always_comb begin
    raw1 = cfg1.enable && (pos_lvl(cfg1.positive_input_select) > neg_lvl(cfg1.negative_input_select));
  end
endmodule : dcc_analog_model

// ### tb/dcc_top_bench.sv
// Self-checking bench for the dual comparator control block.
// Assumes the map header on the include path; APB answers are awaited, only the watchdog ends a wait.
`include "dcc_map.svh"
module dcc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, raw0, raw1, pin6_out, pin6_oe, pin7_out, pin7_oe, current_enable;
  logic [2:0] vector_ack = 0, event_out;
  logic [7:0][6:0] pin_lvl = '0;
  logic [7:0] current_pin_en, v;
  logic [5:0] scaler_factor;
  logic [3:0] current_trim_value;
  dcc_pkg::dcc_comp_cfg_t comp0_cfg, comp1_cfg;
  dcc_pkg::dcc_irq_t irq_req;
  int err_count = 0, checks = 0;
  int ev1 = 0;
  logic [31:0] seed = 32'h51;
  always #5 pclk = ~pclk;
  // Counts comparator one event pulses as sampled at the clock edge
  always @(posedge pclk) if (event_out[1] === 1'b1) ev1++;
  dcc_top i_dcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp0_raw(raw0), .comp1_raw(raw1), .vector_ack(vector_ack), .comp0_cfg(comp0_cfg),
    .comp1_cfg(comp1_cfg), .scaler_factor(scaler_factor), .pin6_out(pin6_out), .pin6_oe(pin6_oe),
    .pin7_out(pin7_out), .pin7_oe(pin7_oe), .current_enable(current_enable),
    .current_pin_en(current_pin_en), .current_trim_value(current_trim_value), .event_out(event_out),
    .irq_req(irq_req));
  dcc_analog_model i_dcc_analog_model (.pin_lvl(pin_lvl), .cfg0(comp0_cfg), .cfg1(comp1_cfg),
    .fac(scaler_factor), .raw0(raw0), .raw1(raw1));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high, then one released edge
  // so that the next call never reassigns psel in the same time step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rdat,
                     output logic err);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata[7:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1, idx, d, r, e);
  endtask : wr
  task automatic rd(input logic [5:0] idx);
    logic e;
    apb(0, idx, 8'h00, v, e);
  endtask : rd
  // Drive comparator inputs on pins 0 and 1 against the half-supply scaler
  task automatic drive(input logic c0, input logic c1);
    pin_lvl[0] <= c0 ? 7'd60 : 7'd4;
    pin_lvl[1] <= c1 ? 7'd60 : 7'd4;
    repeat (10) @(posedge pclk);
  endtask : drive
  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #300us;
    err_count++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] mask [10];
    logic [7:0] d, r;
    logic e;
    logic [1:0] wpos [4];
    logic [2:0] negpin [5];
    mask = '{`DCC_MASK_CTRL, `DCC_MASK_CTRL, `DCC_MASK_INSEL, `DCC_MASK_INSEL, `DCC_MASK_ROUTE,
             `DCC_MASK_SCALER, `DCC_MASK_WINDOW, 8'h00, `DCC_MASK_CURR, `DCC_MASK_TRIM};
    wpos = '{2'b10, 2'b01, 2'b11, 2'b00};
    negpin = '{3'd0, 3'd1, 3'd3, 3'd5, 3'd7};
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rd(i);
      chk(v, `DCC_RESET_VAL); // reset values
    end
    apb(0, 6'd10, 8'h00, r, e);
    chk(e, 1);
    $display("test reset done");
    for (int i = 0; i < 10; i++) if (i != 7) begin
      d = rnd();
      wr(i, d);
      rd(i);
      chk(v, d & mask[i]); // reserved bits read zero
      if (i == 5) chk(scaler_factor, d[5:0]);
      if (i == 9) chk(current_trim_value, d[3:0]);
      wr(i, 8'h00);
    end
    $display("test random access done");
    // Random window settings above may have left the window flag set
    wr(7, 8'h07);
    wr(2, 8'h07);
    wr(3, 8'h0f);
    wr(5, 8'd31);
    wr(0, 8'hd1);
    wr(1, 8'h01);
    wr(4, 8'h03);
    chk(comp0_cfg, 9'h107);
    drive(1, 0);
    chk({pin7_out, pin7_oe, pin6_out, pin6_oe}, 4'b1101);
    rd(7);
    chk(v[5:0], 6'h11); // rise sets flag
    chk(irq_req.comp0_irq_level, 2'b01);
    wr(7, 8'h01);
    rd(7);
    chk(v[2:0], 3'b000); // write one clears
    drive(1, 1);
    rd(7);
    chk(v[5:0], 6'h32); // toggle mode
    chk(irq_req.comp1_irq_level, 2'b00); // level zero
    chk(ev1, 1);
    vector_ack <= 3'b010;
    @(posedge pclk);
    vector_ack <= 3'b000;
    drive(0, 1);
    rd(7);
    chk(v[5:0], 6'h20); // vector clears, fall ignored
    $display("test comparators done");
    wr(6, 8'h16);
    for (int k = 3; k >= 0; k--) begin
      drive(k[1], k[0]);
      rd(7);
      chk(v[7:6], wpos[k]);
    end
    chk(v[2], 1); // entry into inside
    chk(irq_req.window_irq_level, 2'b10);
    wr(7, 8'h04);
    wr(6, 8'h00);
    drive(1, 0);
    rd(7);
    chk(v[7:6], 2'b00);
    chk(v[2], 0); // write one clears
    $display("test window done");
    wr(8, 8'h81);
    for (int c = 0; c < 5; c++) begin
      wr(2, c);
      repeat (3) @(posedge pclk);
      chk({current_enable, current_pin_en}, {1'b1, 8'h01 << negpin[c]});
    end
    wr(8, 8'h82);
    wr(3, 8'h02);
    repeat (3) @(posedge pclk);
    chk({current_enable, current_pin_en}, 9'h108);
    wr(8, 8'h02);
    repeat (3) @(posedge pclk);
    chk({current_enable, current_pin_en}, 9'h000);
    $display("test current source done");
    final_report();
  end
endmodule : dcc_top_bench
